// *** rtl/tse_stage_load.sv ***
// Staging registers and load path for translation entries, with one match port shared by both arrays.
// Assumes the core presents special-register moves and entry operations as one-cycle strobes.
`timescale 1ns/1ns

//  Operation
// - Array select bit 35 picks the target array; 1 selects the second array.
// - Entry index bits 44-47 pick the entry written by the write operation.
// - Entry index also updated by hardware on misses and search results.
// - Next victim bit 63 copied to first array victim state on write.
// - Next victim staging bit updated on misses, searches and entry reads.
// - Entry used for translation only when its in-use bit is one.
// - Guard bit shields second-array entries from invalidate-by-address.
// - Eight-bit process tag held at bits 40-47 of the context register.
// - Zero process tag makes an entry global, matching every process.
// - Address space bit compared with instruction or data space flag.
// - Page size code at 52-55 sets page size; 1001 gives 256 Mbytes.
// - Only page number bits above the page boundary take part in matching.
// - Special register 0x270 decodes as the select staging register.
// - Staged page information moves into the array when loading is issued.
// - Caching-inhibited pages send loads and stores straight to memory; this block only raises lookup_uncached on a hit to such a page.
module tse_stage_load #(
    parameter int ENTRIES = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic spr_wr,
    input wire logic spr_rd,
    input wire logic [9:0] spr_num,
    input wire logic [31:0] spr_wdata,
    output logic [31:0] spr_rdata,
    input wire logic entry_write,
    input wire logic entry_read,
    input wire logic miss_event,
    input wire logic [3:0] miss_index,
    input wire logic search_done,
    input wire logic search_hit,
    input wire logic [3:0] search_index,
    input wire logic hw_victim,
    input wire logic inval_va,
    input wire logic [19:0] inval_epn,
    input wire logic lookup_array,
    input wire logic [3:0] lookup_index,
    input wire logic [19:0] lookup_epn,
    input wire logic [7:0] current_pid,
    input wire logic instr_access,
    input wire logic instr_space_flag,
    input wire logic data_space_flag,
    output logic lookup_hit,
    output logic lookup_uncached,
    output logic victim_state_reg,
    output logic load_busy
);

    // ------------------------------------------------------------
    // Staging registers
    // ------------------------------------------------------------
    logic [31:0] stage_select_reg, stage_select_next;
    logic [31:0] stage_context_reg, stage_context_next;
    logic [31:0] stage_page_reg, stage_page_next;
    logic victim_state_next;
    logic [31:0] rdata_next;
    logic [31:0] spr_rdata_reg;

    always_comb begin
        stage_select_next = stage_select_reg;
        stage_context_next = stage_context_reg;
        stage_page_next = stage_page_reg;
        victim_state_next = victim_state_reg;
        if (spr_wr && spr_num == tse_pkg::SPR_STAGE_SELECT) begin
            stage_select_next = spr_wdata;
        end
        if (spr_wr && spr_num == tse_pkg::SPR_STAGE_CONTEXT) begin
            stage_context_next = spr_wdata;
        end
        if (spr_wr && spr_num == tse_pkg::SPR_STAGE_PAGE) begin
            stage_page_next = spr_wdata;
        end
        // Hardware updates come after software so a same-cycle event is not lost.
        if (miss_event) begin
            stage_select_next[tse_pkg::ENTRY_INDEX_LSB +: 4] = miss_index;
            stage_select_next[tse_pkg::NEXT_VICTIM_BIT] = hw_victim;
        end
        if (search_done) begin
            stage_select_next[tse_pkg::ENTRY_INDEX_LSB +: 4] = search_hit ? search_index : miss_index;
            stage_select_next[tse_pkg::NEXT_VICTIM_BIT] = hw_victim;
        end
        if (entry_read) begin
            stage_select_next[tse_pkg::NEXT_VICTIM_BIT] = hw_victim;
        end
        // A refused write during a load must not disturb the victim state either.
        if (entry_write && !load_busy) begin
            victim_state_next = stage_select_reg[tse_pkg::NEXT_VICTIM_BIT];
        end
    end

    always_comb begin
        rdata_next = spr_rdata_reg;
        if (spr_rd) begin
            unique case (spr_num)
                tse_pkg::SPR_STAGE_SELECT: rdata_next = stage_select_reg;
                tse_pkg::SPR_STAGE_CONTEXT: rdata_next = stage_context_reg;
                tse_pkg::SPR_STAGE_PAGE: rdata_next = stage_page_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_select_reg <= tse_pkg::STAGE_RESET;
            stage_context_reg <= tse_pkg::STAGE_RESET;
            stage_page_reg <= tse_pkg::STAGE_RESET;
            victim_state_reg <= 1'b0;
            spr_rdata_reg <= 32'h0000_0000;
        end else begin
            stage_select_reg <= stage_select_next;
            stage_context_reg <= stage_context_next;
            stage_page_reg <= stage_page_next;
            victim_state_reg <= victim_state_next;
            spr_rdata_reg <= rdata_next;
        end
    end

    assign spr_rdata = spr_rdata_reg;

    // ------------------------------------------------------------
    // Load sequencer
    // ------------------------------------------------------------
    // The whole entry word is written in one edge, so a lookup never sees a torn entry.
    tse_pkg::tse_state_e state_reg, state_next;
    logic [63:0] wr_word_reg, wr_word_next;
    logic wr_array_reg, wr_array_next;
    logic [3:0] wr_index_reg, wr_index_next;

    always_comb begin
        state_next = state_reg;
        wr_word_next = wr_word_reg;
        wr_array_next = wr_array_reg;
        wr_index_next = wr_index_reg;
        unique case (state_reg)
            tse_pkg::TSE_IDLE: begin
                if (entry_write) begin
                    wr_word_next = {stage_context_reg, stage_page_reg};
                    wr_array_next = stage_select_reg[tse_pkg::ARRAY_SELECT_BIT];
                    wr_index_next = stage_select_reg[tse_pkg::ENTRY_INDEX_LSB +: 4];
                    state_next = tse_pkg::TSE_LOAD;
                end
            end
            tse_pkg::TSE_LOAD: state_next = tse_pkg::TSE_DONE;
            tse_pkg::TSE_DONE: state_next = tse_pkg::TSE_IDLE;
            default: state_next = tse_pkg::TSE_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= tse_pkg::TSE_IDLE;
            wr_word_reg <= 64'h0000_0000_0000_0000;
            wr_array_reg <= 1'b0;
            wr_index_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            wr_word_reg <= wr_word_next;
            wr_array_reg <= wr_array_next;
            wr_index_reg <= wr_index_next;
        end
    end

    // ------------------------------------------------------------
    // Entry arrays and validity
    // ------------------------------------------------------------
    logic commit;
    logic [63:0] word0, word1, word;
    logic [ENTRIES-1:0] valid0_reg, valid0_next, valid1_reg, valid1_next;
    logic [ENTRIES-1:0] guard1_reg, guard1_next;
    logic [19:0] epn1_reg [ENTRIES];
    logic [19:0] mask1_reg [ENTRIES];
    logic [19:0] epn0_reg [ENTRIES];
    logic [19:0] mask0_reg [ENTRIES];

    assign commit = state_reg == tse_pkg::TSE_LOAD;

    tse_entry_mem #(.WIDTH(64), .DEPTH(ENTRIES)) u_array0 (
        .clock(clock),
        .wr_en(commit && !wr_array_reg),
        .wr_addr(wr_index_reg),
        .wr_data(wr_word_reg),
        .rd_addr(lookup_index),
        .rd_data(word0)
    );

    tse_entry_mem #(.WIDTH(64), .DEPTH(ENTRIES)) u_array1 (
        .clock(clock),
        .wr_en(commit && wr_array_reg),
        .wr_addr(wr_index_reg),
        .wr_data(wr_word_reg),
        .rd_addr(lookup_index),
        .rd_data(word1)
    );

    // Page mask: size code n covers 4^n Kbytes, so the low 2*(n-1) page number bits are offset.
    function automatic logic [19:0] page_mask(input logic [3:0] code);
        logic [4:0] drop;
        drop = (code > tse_pkg::SIZE_4K) ? {code - tse_pkg::SIZE_4K, 1'b0} : 5'h00;
        page_mask = (drop > 5'd20) ? 20'h00000 : (20'hfffff << drop);
    endfunction

    always_comb begin
        valid0_next = valid0_reg;
        valid1_next = valid1_reg;
        guard1_next = guard1_reg;
        if (inval_va) begin
            for (int i = 0; i < ENTRIES; i++) begin
                if (((epn0_reg[i] ^ inval_epn) & mask0_reg[i]) == 20'h00000) begin
                    valid0_next[i] = 1'b0;
                end
                if ((((epn1_reg[i] ^ inval_epn) & mask1_reg[i]) == 20'h00000) && !guard1_reg[i]) begin
                    valid1_next[i] = 1'b0;
                end
            end
        end
        // The commit comes last so a same-cycle invalidate, matched on stale contents, cannot drop it.
        if (commit) begin
            if (wr_array_reg) begin
                valid1_next[wr_index_reg] = wr_word_reg[32 + tse_pkg::VALID_BIT];
                guard1_next[wr_index_reg] = wr_word_reg[32 + tse_pkg::GUARD_BIT];
            end else begin
                valid0_next[wr_index_reg] = wr_word_reg[32 + tse_pkg::VALID_BIT];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            valid0_reg <= '0;
            valid1_reg <= '0;
            guard1_reg <= '0;
        end else begin
            valid0_reg <= valid0_next;
            valid1_reg <= valid1_next;
            guard1_reg <= guard1_next;
        end
    end

    always_ff @(posedge clock) begin
        if (commit && !wr_array_reg) begin
            epn0_reg[wr_index_reg] <= wr_word_reg[tse_pkg::EPN_LSB +: 20];
            mask0_reg[wr_index_reg] <= page_mask(wr_word_reg[32 + tse_pkg::SIZE_LSB +: 4]);
        end
        if (commit && wr_array_reg) begin
            epn1_reg[wr_index_reg] <= wr_word_reg[tse_pkg::EPN_LSB +: 20];
            mask1_reg[wr_index_reg] <= page_mask(wr_word_reg[32 + tse_pkg::SIZE_LSB +: 4]);
        end
    end

    // ------------------------------------------------------------
    // Lookup of one addressed entry, answered two cycles later
    // ------------------------------------------------------------
    logic sel_reg, valid_q_reg;
    logic [19:0] epn_q_reg;
    logic [7:0] pid_q_reg;
    logic space_q_reg;
    logic tag_ok, space_ok, page_ok, hit_next;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sel_reg <= 1'b0;
            valid_q_reg <= 1'b0;
            epn_q_reg <= 20'h00000;
            pid_q_reg <= 8'h00;
            space_q_reg <= 1'b0;
            lookup_hit <= 1'b0;
            lookup_uncached <= 1'b0;
        end else begin
            sel_reg <= lookup_array;
            valid_q_reg <= lookup_array ? valid1_reg[lookup_index] : valid0_reg[lookup_index];
            epn_q_reg <= lookup_epn;
            pid_q_reg <= current_pid;
            space_q_reg <= instr_access ? instr_space_flag : data_space_flag;
            lookup_hit <= hit_next;
            lookup_uncached <= hit_next && word[tse_pkg::CI_BIT];
        end
    end

    always_comb begin
        word = sel_reg ? word1 : word0;
        tag_ok = word[32 + tse_pkg::TAG_LSB +: 8] == tse_pkg::GLOBAL_TAG
            || word[32 + tse_pkg::TAG_LSB +: 8] == pid_q_reg;
        space_ok = word[32 + tse_pkg::SPACE_BIT] == space_q_reg;
        page_ok = ((word[tse_pkg::EPN_LSB +: 20] ^ epn_q_reg)
            & page_mask(word[32 + tse_pkg::SIZE_LSB +: 4])) == 20'h00000;
        hit_next = valid_q_reg && word[32 + tse_pkg::VALID_BIT] && tag_ok && space_ok && page_ok;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            load_busy <= 1'b0;
        end else begin
            load_busy <= state_next != tse_pkg::TSE_IDLE;
        end
    end

endmodule

// *** rtl/tse_pkg.sv ***
// Package of the translation entry staging block: register numbers, field positions and codes.
// Assumes the register numbers arrive from the core's special-register move decode.
package tse_pkg;

    // ------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------
    localparam logic [9:0] SPR_STAGE_SELECT = 10'h270;
    localparam logic [9:0] SPR_STAGE_CONTEXT = 10'h271;
    localparam logic [9:0] SPR_STAGE_PAGE = 10'h272;

    // ------------------------------------------------------------
    // Field positions, in big-endian numbering 32..63 mapped to LSB index 63-n
    // ------------------------------------------------------------
    localparam int ARRAY_SELECT_BIT = 63 - 35;
    localparam int ENTRY_INDEX_LSB = 63 - 47;
    localparam int NEXT_VICTIM_BIT = 63 - 63;
    localparam int VALID_BIT = 63 - 32;
    localparam int GUARD_BIT = 63 - 33;
    localparam int TAG_LSB = 63 - 47;
    localparam int SPACE_BIT = 63 - 51;
    localparam int SIZE_LSB = 63 - 55;
    localparam int EPN_LSB = 63 - 51;
    localparam int CI_BIT = 63 - 60;

    // ------------------------------------------------------------
    // Values after reset and codes
    // ------------------------------------------------------------
    localparam logic [31:0] STAGE_RESET = 32'h0000_0000;
    localparam logic [3:0] SIZE_4K = 4'h1;
    localparam logic [3:0] SIZE_256M = 4'h9;
    localparam logic [7:0] GLOBAL_TAG = 8'h00;

    typedef enum logic [2:0] {
        TSE_IDLE = 3'b001,
        TSE_LOAD = 3'b010,
        TSE_DONE = 3'b100
    } tse_state_e;

endpackage

// *** rtl/tse_entry_mem.sv ***
// Entry store of one translation array, one word per entry, registered read port.
// Assumes a single writer on the core clock.
`timescale 1ns/1ns
module tse_entry_mem #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

// *** dv/tse_stage_load_props.sv ***
// Checker of the translation entry staging block, watching its top-level ports.
// Assumes the single core clock and the active-low reset of that module.
`timescale 1ns/1ns
module tse_stage_load_props #(
    parameter int ENTRIES = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic spr_wr,
    input wire logic spr_rd,
    input wire logic [9:0] spr_num,
    input wire logic [31:0] spr_rdata,
    input wire logic entry_write,
    input wire logic entry_read,
    input wire logic miss_event,
    input wire logic [3:0] miss_index,
    input wire logic search_done,
    input wire logic hw_victim,
    input wire logic lookup_hit,
    input wire logic lookup_uncached,
    input wire logic victim_state_reg,
    input wire logic load_busy
);
    // ------------------------------------------------------------
    // Run length of the busy flag
    // ------------------------------------------------------------
    logic [2:0] busy_run_reg;
    logic [2:0] busy_run_next;

    always_comb begin
        busy_run_next = load_busy ? busy_run_reg + {2'h0, busy_run_reg != 3'h7} : 3'h0;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_run_reg <= 3'h0;
        end else begin
            busy_run_reg <= busy_run_next;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    unmapped_read_a: assert property (spr_rd && spr_num != tse_pkg::SPR_STAGE_SELECT
        && spr_num != tse_pkg::SPR_STAGE_CONTEXT && spr_num != tse_pkg::SPR_STAGE_PAGE |=> spr_rdata == 32'h0)
        else $error("unmapped register read returned nonzero data");
    rdata_hold_a: assert property (!spr_rd |=> $stable(spr_rdata))
        else $error("read data changed without a read");
    load_start_a: assert property (entry_write && !load_busy |=> load_busy)
        else $error("entry write did not start the load");
    load_len_a: assert property ($rose(load_busy) |-> load_busy[*2] ##1 !load_busy)
        else $error("load did not last two cycles");
    busy_bound_a: assert property (busy_run_reg <= 3'h2)
        else $error("busy flag held too long");
    victim_when_a: assert property ($changed(victim_state_reg) |-> $past(entry_write) || $past(load_busy))
        else $error("victim state changed outside a load");
    uncached_hit_a: assert property (lookup_uncached |-> lookup_hit)
        else $error("uncached flag without a hit");
    miss_update_a: assert property (miss_event && !search_done && !entry_read && !spr_wr ##1
        (spr_rd && spr_num == tse_pkg::SPR_STAGE_SELECT && !spr_wr && !miss_event && !search_done && !entry_read)
        |=> spr_rdata[tse_pkg::ENTRY_INDEX_LSB +: 4] == $past(miss_index, 2)
        && spr_rdata[tse_pkg::NEXT_VICTIM_BIT] == $past(hw_victim, 2))
        else $error("miss did not update index and victim fields");
endmodule

bind tse_stage_load tse_stage_load_props #(.ENTRIES(ENTRIES)) u_tse_stage_load_props (
    .clock(clock), .reset_n(reset_n), .spr_wr(spr_wr), .spr_rd(spr_rd), .spr_num(spr_num),
    .spr_rdata(spr_rdata), .entry_write(entry_write), .entry_read(entry_read), .miss_event(miss_event),
    .miss_index(miss_index), .search_done(search_done), .hw_victim(hw_victim), .lookup_hit(lookup_hit),
    .lookup_uncached(lookup_uncached), .victim_state_reg(victim_state_reg), .load_busy(load_busy)
);

// *** dv/tse_stage_load_tb_top.sv ***
// Self-checking bench of the translation entry staging block.
// Assumes the block answers lookups two edges after the request.
`timescale 1ns/1ns
module tse_stage_load_tb_top;
    logic clock, reset_n, spr_wr, spr_rd, entry_write, entry_read, miss_event, search_done, search_hit;
    logic hw_victim, inval_va, lookup_array, instr_access, instr_space_flag, data_space_flag;
    logic lookup_hit, lookup_uncached, victim_state_reg, load_busy;
    logic [9:0] spr_num;
    logic [31:0] spr_wdata, spr_rdata;
    logic [3:0] miss_index, search_index, lookup_index;
    logic [19:0] inval_epn, lookup_epn;
    logic [7:0] current_pid;
    int mismatches, n_tests;

    tse_stage_load #(.ENTRIES(16)) u_tse_stage_load (
        .clock(clock), .reset_n(reset_n), .spr_wr(spr_wr), .spr_rd(spr_rd), .spr_num(spr_num),
        .spr_wdata(spr_wdata), .spr_rdata(spr_rdata), .entry_write(entry_write), .entry_read(entry_read),
        .miss_event(miss_event), .miss_index(miss_index), .search_done(search_done), .search_hit(search_hit),
        .search_index(search_index), .hw_victim(hw_victim), .inval_va(inval_va), .inval_epn(inval_epn),
        .lookup_array(lookup_array), .lookup_index(lookup_index), .lookup_epn(lookup_epn),
        .current_pid(current_pid), .instr_access(instr_access), .instr_space_flag(instr_space_flag),
        .data_space_flag(data_space_flag), .lookup_hit(lookup_hit), .lookup_uncached(lookup_uncached),
        .victim_state_reg(victim_state_reg), .load_busy(load_busy)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic tick;
        @(posedge clock);
        #1;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [9:0] num, input logic [31:0] d);
        spr_wr = 1'b1;
        spr_num = num;
        spr_wdata = d;
        tick;
        spr_wr = 1'b0;
        tick;
    endtask

    task automatic rd(input logic [9:0] num, input logic [31:0] exp);
        spr_rd = 1'b1;
        spr_num = num;
        tick;
        spr_rd = 1'b0;
        check(spr_rdata, exp);
        tick;
    endtask

    // Fills all three staging registers, then loads and waits for the load to finish.
    task automatic stage(input logic [31:0] sel, input logic [31:0] ctx, input logic [31:0] pg);
        wr(tse_pkg::SPR_STAGE_SELECT, sel);
        wr(tse_pkg::SPR_STAGE_CONTEXT, ctx);
        wr(tse_pkg::SPR_STAGE_PAGE, pg);
        entry_write = 1'b1;
        tick;
        entry_write = 1'b0;
        for (int i = 0; i < 8 && load_busy !== 1'b0; i++) begin
            tick;
        end
        if (load_busy !== 1'b0) begin
            mismatches++;
            tally_and_finish;
        end
    endtask

    // Space holds instruction access, instruction space flag, data space flag; exp is hit, uncached.
    task automatic look(input logic arr, input logic [3:0] idx, input logic [19:0] effective_page_num, input logic [7:0] pid,
                        input logic [2:0] space, input logic [1:0] exp);
        lookup_array = arr;
        lookup_index = idx;
        lookup_epn = effective_page_num;
        current_pid = pid;
        {instr_access, instr_space_flag, data_space_flag} = space;
        tick;
        tick;
        check({30'h0, lookup_hit, lookup_uncached}, {30'h0, exp});
    endtask

    task automatic inval(input logic [19:0] effective_page_num);
        inval_va = 1'b1;
        inval_epn = effective_page_num;
        tick;
        inval_va = 1'b0;
        tick;
        tick;
    endtask

    // Kind holds miss, search done, search hit and entry read strobes.
    task automatic hw_op(input logic [3:0] kind, input logic [3:0] idx, input logic v, input logic [31:0] exp);
        {miss_event, search_done, search_hit, entry_read} = kind;
        // The unused index source carries the inverse, so a wrong source choice shows.
        miss_index = kind[1] ? ~idx : idx;
        search_index = kind[1] ? idx : ~idx;
        hw_victim = v;
        tick;
        {miss_event, search_done, search_hit, entry_read} = 4'h0;
        rd(tse_pkg::SPR_STAGE_SELECT, exp);
    endtask

    initial begin
        {reset_n, spr_wr, spr_rd, entry_write, entry_read, miss_event, search_done, search_hit} = 8'h0;
        {hw_victim, inval_va, lookup_array, instr_access, instr_space_flag, data_space_flag} = 6'h0;
        {spr_num, spr_wdata, miss_index, search_index, lookup_index} = 54'h0;
        {inval_epn, lookup_epn, current_pid} = 48'h0;
        mismatches = 0;
        n_tests = 0;
        repeat (6) @(posedge clock);
        #1;
        reset_n = 1'b1;
        tick;
        rd(tse_pkg::SPR_STAGE_SELECT, tse_pkg::STAGE_RESET);
        rd(tse_pkg::SPR_STAGE_CONTEXT, tse_pkg::STAGE_RESET);
        rd(tse_pkg::SPR_STAGE_PAGE, tse_pkg::STAGE_RESET);
        rd(10'h273, 32'h0);
        stage(32'h1003_0000, 32'h8000_0900, 32'hc000_0008);
        rd(tse_pkg::SPR_STAGE_SELECT, 32'h1003_0000);
        look(1'b1, 4'h3, 20'hc0000, 8'h55, 3'b000, 2'b11);
        look(1'b1, 4'h3, 20'hcabcd, 8'h00, 3'b000, 2'b11);
        look(1'b1, 4'h3, 20'hd0000, 8'h00, 3'b000, 2'b00);
        look(1'b1, 4'h2, 20'hc0000, 8'h00, 3'b000, 2'b00);
        look(1'b0, 4'h3, 20'hc0000, 8'h00, 3'b000, 2'b00);
        look(1'b1, 4'h3, 20'hc0000, 8'h00, 3'b110, 2'b00);
        look(1'b1, 4'h3, 20'hc0000, 8'h00, 3'b101, 2'b11);
        look(1'b1, 4'h3, 20'hc0000, 8'h00, 3'b001, 2'b00);
        stage(32'h1004_0000, 32'h8042_0900, 32'hc000_0000);
        look(1'b1, 4'h4, 20'hc0000, 8'h42, 3'b000, 2'b10);
        look(1'b1, 4'h4, 20'hc0000, 8'h43, 3'b000, 2'b00);
        stage(32'h1003_0000, 32'hc000_0900, 32'hc000_0008);
        inval(20'hc1234);
        look(1'b1, 4'h3, 20'hc0000, 8'h00, 3'b000, 2'b11);
        look(1'b1, 4'h4, 20'hc0000, 8'h42, 3'b000, 2'b00);
        // A first-array entry has no guard, so the invalidate must remove it.
        stage(32'h0005_0001, 32'hc000_0100, 32'h1234_5000);
        check({31'h0, victim_state_reg}, 32'h1);
        look(1'b0, 4'h5, 20'h12345, 8'h00, 3'b000, 2'b10);
        look(1'b0, 4'h5, 20'h12344, 8'h00, 3'b000, 2'b00);
        inval(20'h12345);
        look(1'b0, 4'h5, 20'h12345, 8'h00, 3'b000, 2'b00);
        wr(tse_pkg::SPR_STAGE_SELECT, 32'h1000_0000);
        hw_op(4'b1000, 4'h9, 1'b1, 32'h1009_0001);
        hw_op(4'b0110, 4'h6, 1'b0, 32'h1006_0000);
        hw_op(4'b0100, 4'h2, 1'b1, 32'h1002_0001);
        hw_op(4'b0001, 4'hf, 1'b0, 32'h1002_0000);
        // A reset in mid-run must clear the victim state, the staging registers and every valid bit.
        reset_n = 1'b0;
        tick;
        reset_n = 1'b1;
        tick;
        check({31'h0, victim_state_reg}, 32'h0);
        rd(tse_pkg::SPR_STAGE_SELECT, tse_pkg::STAGE_RESET);
        look(1'b1, 4'h3, 20'hc0000, 8'h00, 3'b000, 2'b00);
        tally_and_finish;
    end
endmodule
